/* File: spl_top.sv */
// Device end of the two-channel packet link with its word buffers
`timescale 1ns/100ps
module spl_top
   import spl_pkg::*;
(
   input wire logic clock,
   input wire logic rst_b,
   input wire logic status_mode,
   input wire logic tenb_b,
   input wire logic tsx,
   input wire logic tsop,
   input wire logic teop,
   input wire logic [1:0] tmod,
   input wire logic tprty,
   input wire logic [SPL_DW-1:0] tdat,
   input wire logic [SPL_CW-1:0] tadr,
   output logic stpa,
   output logic ptpa,
   output logic [SPL_NCH-1:0] dtpa,
   output logic tx_par_err,
   output logic tx_overflow,
   output logic [SPL_NCH-1:0] tx_out_valid,
   input wire logic [SPL_NCH-1:0] tx_out_ready,
   output logic [SPL_DW-1:0] tx_out_data [SPL_NCH],
   output logic [1:0] tx_out_mod [SPL_NCH],
   output logic [SPL_NCH-1:0] tx_out_sop,
   output logic [SPL_NCH-1:0] tx_out_eop,
   input wire logic [SPL_NCH-1:0] rx_in_valid,
   output logic [SPL_NCH-1:0] rx_in_ready,
   input wire logic [SPL_DW-1:0] rx_in_data [SPL_NCH],
   input wire logic [1:0] rx_in_mod [SPL_NCH],
   input wire logic [SPL_NCH-1:0] rx_in_sop,
   input wire logic [SPL_NCH-1:0] rx_in_eop,
   input wire logic [SPL_NCH-1:0] rx_in_err,
   input wire logic renb_b,
   output logic [SPL_DW-1:0] rdat,
   output logic rprty,
   output logic [1:0] rmod,
   output logic rsop,
   output logic reop,
   output logic rerr,
   output logic rval,
   output logic rsx
);
   spl_fifo_if txq [SPL_NCH] ();
   spl_fifo_if rxq [SPL_NCH] ();

   logic [SPL_NCH-1:0] tx_wr_valid;
   logic [SPL_NCH-1:0] tx_wr_ready;
   spl_word_t tx_wr_word;
   logic [SPL_CW-1:0] tx_sel;
   logic tx_par_bad;
   logic tx_lost;
   logic [SPL_AW:0] tx_free [SPL_NCH];
   logic [SPL_NCH-1:0] tx_avail;
   logic [SPL_NCH-1:0] tx_head_valid;
   spl_word_t tx_head [SPL_NCH];
   logic [SPL_NCH-1:0] tx_pop;

   logic [SPL_AW:0] rx_free [SPL_NCH];
   logic [SPL_NCH-1:0] rx_has;
   spl_word_t rx_head [SPL_NCH];
   logic [SPL_NCH-1:0] rx_pop;

   spl_rx_state_t state;
   spl_rx_state_t next_state;
   logic [SPL_CW-1:0] cur;
   logic [SPL_CW-1:0] next_cur;
   logic addr_known;
   logic take;
   logic [SPL_CW-1:0] alt;
   logic [SPL_CW-1:0] pick;
   logic any_ready;
   logic send_word;
   logic send_addr;
   logic [SPL_CW-1:0] word_ch;
   spl_word_t word;
   logic [SPL_DW-1:0] next_rdat;
   logic packet_mode;
   // Next values, decoded apart from their registers
   logic next_stpa;
   logic next_ptpa;
   logic next_rval;
   logic next_rsx;
   logic next_rsop;
   logic next_reop;
   logic [1:0] next_rmod;
   logic next_rerr;
   logic next_rprty;

   assign packet_mode = status_mode == SPL_MODE_PACKET;

   // Transmit side: pin decoder feeding one buffer per channel
   spl_tx_decode u_tx_decode (
      .clock(clock),
      .rst_b(rst_b),
      .tenb_b(tenb_b),
      .tsx(tsx),
      .tsop(tsop),
      .teop(teop),
      .tmod(tmod),
      .tprty(tprty),
      .tdat(tdat),
      .wr_ready(tx_wr_ready),
      .wr_valid(tx_wr_valid),
      .wr_word(tx_wr_word),
      .sel(tx_sel),
      .par_err(tx_par_bad),
      .overflow(tx_lost)
   );

   genvar i;
   generate
      for (i = 0; i < SPL_NCH; i++) begin : g_ch
         spl_fifo u_tx_fifo (
            .clock(clock),
            .rst_b(rst_b),
            .q(txq[i])
         );
         spl_fifo u_rx_fifo (
            .clock(clock),
            .rst_b(rst_b),
            .q(rxq[i])
         );
         assign txq[i].wr_valid = tx_wr_valid[i];
         assign txq[i].wr_word = tx_wr_word;
         assign txq[i].rd_ready = tx_pop[i];
         assign tx_wr_ready[i] = txq[i].wr_ready;
         assign tx_free[i] = txq[i].free;
         assign tx_avail[i] = spl_avail(tx_free[i]);
         assign tx_head_valid[i] = txq[i].rd_valid;
         assign tx_head[i] = txq[i].rd_word;
         // Output stage refills whenever it is empty or being drained
         assign tx_pop[i] = tx_head_valid[i] &&
                            (!tx_out_valid[i] || tx_out_ready[i]);

         assign rxq[i].wr_valid = rx_in_valid[i] && rx_in_ready[i];
         assign rxq[i].wr_word.data = rx_in_data[i];
         assign rxq[i].wr_word.mod = rx_in_mod[i];
         assign rxq[i].wr_word.sop = rx_in_sop[i];
         assign rxq[i].wr_word.eop = rx_in_eop[i];
         assign rxq[i].wr_word.err = rx_in_err[i];
         assign rxq[i].rd_ready = rx_pop[i];
         assign rx_free[i] = rxq[i].free;
         assign rx_has[i] = rxq[i].rd_valid;
         assign rx_head[i] = rxq[i].rd_word;
         assign rx_pop[i] = send_word && (word_ch == SPL_CW'(i));
      end
   endgenerate

   // Selected status lags a new selection by one clock
   assign next_stpa = tx_avail[tx_sel];
   // Polled answer only while polling is the chosen mode
   assign next_ptpa = packet_mode && tx_avail[tadr];

   // Transmit status towards the link layer
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         stpa <= 1'b0;
         ptpa <= 1'b0;
         dtpa <= '0;
         tx_par_err <= 1'b0;
         tx_overflow <= 1'b0;
      end else begin
         stpa <= next_stpa;
         dtpa <= tx_avail;
         ptpa <= next_ptpa;
         tx_par_err <= tx_par_bad;
         tx_overflow <= tx_lost;
      end
   end

   // Transmit words handed to the user side, one register per channel
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         tx_out_valid <= '0;
         tx_out_sop <= '0;
         tx_out_eop <= '0;
         for (int c = 0; c < SPL_NCH; c++) begin
            tx_out_data[c] <= '0;
            tx_out_mod[c] <= SPL_MOD_ALL;
         end
      end else begin
         for (int c = 0; c < SPL_NCH; c++) begin
            if (tx_pop[c]) begin
               tx_out_valid[c] <= 1'b1;
               tx_out_data[c] <= tx_head[c].data;
               tx_out_mod[c] <= tx_head[c].mod;
               tx_out_sop[c] <= tx_head[c].sop;
               tx_out_eop[c] <= tx_head[c].eop;
            end else if (tx_out_ready[c]) begin
               tx_out_valid[c] <= 1'b0;
            end
         end
      end
   end

   // Registered ready keeps margin for the word already in flight
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         rx_in_ready <= '0;
      end else begin
         for (int c = 0; c < SPL_NCH; c++) begin
            rx_in_ready[c] <= rx_free[c] >= SPL_READY_FREE;
         end
      end
   end

   // Receive scheduling: finish the open packet, then rotate channels
   assign take = !renb_b;
   assign alt = cur + 1'b1;
   assign pick = rx_has[alt] ? alt : cur;
   assign any_ready = |rx_has;
   assign word_ch = (state == SPL_RX_PKT) ? cur : pick;
   assign word = rx_head[word_ch];

   always_comb begin
      send_word = 1'b0;
      send_addr = 1'b0;
      next_state = state;
      next_cur = cur;
      if (take) begin
         case (state)
            SPL_RX_PKT: begin
               // Starved mid-packet: idle cycles, no address change
               if (rx_has[cur]) begin
                  send_word = 1'b1;
                  if (word.eop) begin
                     next_state = SPL_RX_GAP;
                  end
               end
            end
            SPL_RX_GAP: begin
               if (any_ready) begin
                  if (pick == cur && addr_known) begin
                     send_word = 1'b1;
                     if (!word.eop) begin
                        next_state = SPL_RX_PKT;
                     end
                  end else begin
                     send_addr = 1'b1;
                     next_cur = pick;
                  end
               end
            end
            default: begin
               next_state = SPL_RX_GAP;
            end
         endcase
      end
   end

   assign next_rdat = send_word ? word.data :
                      send_addr ? {{(SPL_DW-SPL_CW){1'b0}}, pick} :
                      '0;

   // Receive pin next values; the register below only loads them
   assign next_rval = send_word;
   assign next_rsx = send_addr;
   assign next_rsop = send_word && word.sop;
   assign next_reop = send_word && word.eop;
   // Mask and error carry meaning only on the closing word
   assign next_rmod = next_reop ? word.mod : SPL_MOD_ALL;
   assign next_rerr = next_reop && word.err;
   // Parity follows the data, address and idle cycles included
   assign next_rprty = spl_par(next_rdat);

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         state <= SPL_RX_GAP;
         cur <= '0;
         addr_known <= 1'b0;
      end else begin
         state <= next_state;
         cur <= next_cur;
         if (send_addr) begin
            addr_known <= 1'b1;
         end
      end
   end

   // Receive pins change only after an edge with RENB low
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         rdat <= '0;
         rprty <= 1'b0;
         rmod <= SPL_MOD_ALL;
         rsop <= 1'b0;
         reop <= 1'b0;
         rerr <= 1'b0;
         rval <= 1'b0;
         rsx <= 1'b0;
      end else if (take) begin
         rdat <= next_rdat;
         rprty <= next_rprty;
         rval <= next_rval;
         rsx <= next_rsx;
         rsop <= next_rsop;
         reop <= next_reop;
         rmod <= next_rmod;
         rerr <= next_rerr;
      end
   end
endmodule

/* File: spl_pkg.sv */
// Shared constants, types and helpers for the two-channel packet link
// What this block does
// - All link pins are sampled and driven on the single clock.
// - Transmit words are accepted only in cycles where TENB is low.
// - Transmit parity is checked for information only, data never altered.
// - Status mode only gates packet-level polled PTPA; byte-level direct DTPA and STPA run in both modes.
// - STPA goes high when the selected channel has preset free space.
// - One direct available line per channel, independent of selection.
// - STPA follows the currently selected channel, one clock after a new selection.
// - Polled address on TADR answered on PTPA at the next clock edge.
// - With RENB low the device emits an address with RSX or data with RVAL.
// - Receive outputs change on the same edge that samples RENB low.
// - With RENB sampled high the current receive phase is held.
package spl_pkg;
   localparam int SPL_NCH = 2;
   localparam int SPL_CW = 1;
   localparam int SPL_DW = 32;
   localparam int SPL_DEPTH = 16;
   localparam int SPL_AW = 4;
   localparam logic [SPL_AW:0] SPL_DEPTH_W = 5'h10;
   // Free words needed before a channel reports space
   localparam logic [SPL_AW:0] SPL_AVAIL_FREE = 5'h04;
   // Free words needed for the user-side ready to stay high
   localparam logic [SPL_AW:0] SPL_READY_FREE = 5'h02;
   localparam logic [1:0] SPL_MOD_ALL = 2'h0;
   localparam logic SPL_ODD_PARITY = 1'b1;

   typedef struct packed {
      logic [SPL_DW-1:0] data;
      logic [1:0] mod;
      logic sop;
      logic eop;
      logic err;
   } spl_word_t;

   typedef enum logic {
      SPL_MODE_BYTE = 1'b0,
      SPL_MODE_PACKET = 1'b1
   } spl_mode_t;

   typedef enum logic [1:0] {
      SPL_RX_GAP = 2'b00,
      SPL_RX_PKT = 2'b01
   } spl_rx_state_t;

   function automatic logic spl_par(input logic [SPL_DW-1:0] d);
      spl_par = SPL_ODD_PARITY ? ~^d : ^d;
   endfunction

   function automatic logic spl_avail(input logic [SPL_AW:0] free);
      spl_avail = free >= SPL_AVAIL_FREE;
   endfunction
endpackage

/* File: spl_fifo_if.sv */
// Carrier between the top and its per-channel word buffers
`timescale 1ns/100ps
interface spl_fifo_if;
   import spl_pkg::*;
   logic wr_valid;
   spl_word_t wr_word;
   logic wr_ready;
   logic rd_valid;
   spl_word_t rd_word;
   logic rd_ready;
   logic [SPL_AW:0] free;
   modport fifo(input wr_valid, wr_word, rd_ready,
                output wr_ready, rd_valid, rd_word, free);
   modport user(output wr_valid, wr_word, rd_ready,
                input wr_ready, rd_valid, rd_word, free);
endinterface

/* File: spl_fifo.sv */
// Packet word buffer for one channel, show-ahead read
`timescale 1ns/100ps
module spl_fifo
   import spl_pkg::*;
(
   input wire logic clock,
   input wire logic rst_b,
   spl_fifo_if.fifo q
);
   spl_word_t mem [SPL_DEPTH];
   logic [SPL_AW:0] wr_ptr;
   logic [SPL_AW:0] rd_ptr;
   logic [SPL_AW:0] count;
   logic full;
   logic empty;
   logic push;
   logic pop;

   assign count = wr_ptr - rd_ptr;
   assign full = count == SPL_DEPTH_W;
   assign empty = count == '0;
   assign push = q.wr_valid && !full;
   assign pop = q.rd_ready && !empty;
   assign q.wr_ready = !full;
   assign q.rd_valid = !empty;
   assign q.rd_word = mem[rd_ptr[SPL_AW-1:0]];
   assign q.free = SPL_DEPTH_W - count;

   // Storage is left without reset; only the pointers define content
   always_ff @(posedge clock) begin
      if (push) begin
         mem[wr_ptr[SPL_AW-1:0]] <= q.wr_word;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 5'h01;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 5'h01;
         end
      end
   end
endmodule

/* File: spl_tx_decode.sv */
// Transmit pin decoder: in-band selection, word capture, parity check
`timescale 1ns/100ps
module spl_tx_decode
   import spl_pkg::*;
(
   input wire logic clock,
   input wire logic rst_b,
   input wire logic tenb_b,
   input wire logic tsx,
   input wire logic tsop,
   input wire logic teop,
   input wire logic [1:0] tmod,
   input wire logic tprty,
   input wire logic [SPL_DW-1:0] tdat,
   input wire logic [SPL_NCH-1:0] wr_ready,
   output logic [SPL_NCH-1:0] wr_valid,
   output spl_word_t wr_word,
   output logic [SPL_CW-1:0] sel,
   output logic par_err,
   output logic overflow
);
   logic take_data;
   logic take_cmd;
   logic par_bad;

   assign take_data = !tenb_b;
   // TSX with TENB low is a plain word to the same channel
   assign take_cmd = tenb_b && tsx;
   assign par_bad = tprty != spl_par(tdat);
   assign wr_word.data = tdat;
   assign wr_word.mod = teop ? tmod : SPL_MOD_ALL;
   assign wr_word.sop = tsop;
   assign wr_word.eop = teop;
   assign wr_word.err = 1'b0;

   genvar i;
   generate
      for (i = 0; i < SPL_NCH; i++) begin : g_wr
         assign wr_valid[i] = take_data && (sel == SPL_CW'(i));
      end
   endgenerate

   // Pins are same-clock logic, so no synchroniser stages
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         sel <= '0;
         par_err <= 1'b0;
         overflow <= 1'b0;
      end else begin
         if (take_cmd) begin
            sel <= tdat[SPL_CW-1:0];
         end
         // Bad parity is only flagged; the word is still stored
         par_err <= take_data && par_bad;
         // A word into a full buffer is lost when the link ignores status
         overflow <= take_data && !wr_ready[sel];
      end
   end
endmodule

/* File: spl_assertions.sv */
// Concurrent checks on the device end of the packet link
`timescale 1ns/100ps
module spl_checker
   import spl_pkg::*;
(
   input wire logic clock,
   input wire logic rst_b,
   input wire logic status_mode,
   input wire logic tenb_b,
   input wire logic tsx,
   input wire logic [SPL_DW-1:0] tdat,
   input wire logic [SPL_CW-1:0] tadr,
   input wire logic stpa,
   input wire logic ptpa,
   input wire logic [SPL_NCH-1:0] dtpa,
   input wire logic renb_b,
   input wire logic [SPL_DW-1:0] rdat,
   input wire logic rprty,
   input wire logic [1:0] rmod,
   input wire logic rsop,
   input wire logic reop,
   input wire logic rerr,
   input wire logic rval,
   input wire logic rsx
);
   default clocking @(posedge clock);
   endclocking
   default disable iff (!rst_b);
   logic [SPL_CW-1:0] sel;
   // Mirror of the in-band selection
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         sel <= '0;
      end else if (tenb_b && tsx) begin
         sel <= tdat[SPL_CW-1:0];
      end
   end
   sequence s_poll;
      status_mode ##1 1'b1;
   endsequence
   sequence s_byte;
      !status_mode ##1 1'b1;
   endsequence
   sequence s_stall;
      renb_b ##1 1'b1;
   endsequence
   property p_ptpa_poll;
      s_poll |-> ptpa == dtpa[$past(tadr)];
   endproperty
   a_ptpa_poll: assert property (p_ptpa_poll)
      else $error("polled status wrong");
   property p_ptpa_byte;
      s_byte |-> !ptpa;
   endproperty
   a_ptpa_byte: assert property (p_ptpa_byte)
      else $error("polled status in byte mode");
   // Selection lags one edge, so compare with last selection
   property p_stpa_sel;
      stpa == dtpa[$past(sel)];
   endproperty
   a_stpa_sel: assert property (p_stpa_sel)
      else $error("selected status wrong");
   property p_rx_hold;
      s_stall |-> $stable({rdat, rprty, rmod, rsop, reop, rerr, rval, rsx});
   endproperty
   a_rx_hold: assert property (p_rx_hold)
      else $error("receive output moved while held");
   property p_rx_rise;
      $rose(rval) || $rose(rsx) |-> !$past(renb_b);
   endproperty
   a_rx_rise: assert property (p_rx_rise)
      else $error("receive output without enable");
   property p_rx_par;
      rval |-> rprty == ~^rdat;
   endproperty
   a_rx_par: assert property (p_rx_par)
      else $error("receive parity wrong");
   property p_mod_eop;
      rmod != 2'h0 |-> rval && reop;
   endproperty
   a_mod_eop: assert property (p_mod_eop)
      else $error("byte mask without end");
   property p_err_eop;
      rerr |-> rval && reop;
   endproperty
   a_err_eop: assert property (p_err_eop)
      else $error("error flag without end");
endmodule

bind spl_top spl_checker u_chk (.clock, .rst_b, .status_mode, .tenb_b,
   .tsx, .tdat, .tadr, .stpa, .ptpa, .dtpa, .renb_b, .rdat, .rprty, .rmod,
   .rsop, .reop, .rerr, .rval, .rsx);

/* File: spl_link_model.sv */
// Link-layer transmit side driving the device pins
`timescale 1ns/100ps
module spl_link_model
   import spl_pkg::*;
(
   input wire logic clock,
   output logic tenb_b,
   output logic tsx,
   output logic tsop,
   output logic teop,
   output logic [1:0] tmod,
   output logic tprty,
   output logic [SPL_DW-1:0] tdat
);
   initial begin
      {tenb_b, tsx, tsop, teop, tmod, tprty} = 7'h40;
      tdat = 32'h0;
   end
   // One bus cycle, launched after the falling edge
   task automatic cyc(input logic en_b, input logic sx,
         input logic [SPL_DW-1:0] d, input logic sop, input logic eop,
         input logic [1:0] m);
      @(negedge clock);
      tenb_b = en_b;
      tsx = sx;
      tdat = d;
      tsop = sop;
      teop = eop;
      tmod = eop ? m : 2'h0;
      tprty = ~^d;
   endtask
   task automatic sel(input logic ch);
      cyc(1'b1, 1'b1, {31'h0, ch}, 1'b0, 1'b0, 2'h0);
   endtask
   // Flipped data so a stale word never looks valid
   task automatic idle();
      cyc(1'b1, 1'b0, ~tdat, 1'b0, 1'b0, 2'h0);
   endtask
   // Single-word packet whose parity bit is wrong on purpose
   task automatic bad(input logic [SPL_DW-1:0] d);
      @(negedge clock);
      tenb_b = 1'b0;
      tsx = 1'b0;
      tdat = d;
      tsop = 1'b1;
      teop = 1'b1;
      tmod = 2'h0;
      tprty = ^d;
   endtask
endmodule

/* File: spi3_packet_fifo_link_test.sv */
// Self-checking bench for the device end of the packet link
`timescale 1ns/100ps
module spi3_packet_fifo_link_test;
   import spl_pkg::*;
   logic clock, rst_b, status_mode, tenb_b, tsx, tsop, teop, tprty;
   logic stpa, ptpa, tx_par_err, tx_overflow, renb_b;
   logic rprty, rsop, reop, rerr, rval, rsx;
   logic [1:0] tmod, rmod;
   logic [SPL_DW-1:0] tdat, rdat;
   logic [SPL_CW-1:0] tadr;
   logic [SPL_NCH-1:0] dtpa, tx_out_valid, tx_out_ready, tx_out_sop;
   logic [SPL_NCH-1:0] tx_out_eop, rx_in_valid, rx_in_ready, rx_in_sop;
   logic [SPL_NCH-1:0] rx_in_eop, rx_in_err;
   logic [SPL_DW-1:0] tx_out_data [SPL_NCH];
   logic [SPL_DW-1:0] rx_in_data [SPL_NCH];
   logic [1:0] tx_out_mod [SPL_NCH];
   logic [1:0] rx_in_mod [SPL_NCH];
   int n_fail, tests_run;

   spl_top dut (.clock, .rst_b, .status_mode, .tenb_b, .tsx, .tsop, .teop,
      .tmod, .tprty, .tdat, .tadr, .stpa, .ptpa, .dtpa, .tx_par_err,
      .tx_overflow, .tx_out_valid, .tx_out_ready, .tx_out_data, .tx_out_mod,
      .tx_out_sop, .tx_out_eop, .rx_in_valid, .rx_in_ready, .rx_in_data,
      .rx_in_mod, .rx_in_sop, .rx_in_eop, .rx_in_err, .renb_b, .rdat,
      .rprty, .rmod, .rsop, .reop, .rerr, .rval, .rsx);
   spl_link_model link (.clock, .tenb_b, .tsx, .tsop, .teop, .tmod, .tprty,
      .tdat);

   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   task automatic print_verdict();
      $display("Checks %0d, mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [SPL_DW:0] seen,
         input logic [SPL_DW:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   function automatic logic flag(input int k);
      flag = k == 2 ? rsx : k == 3 ? rx_in_ready[0] : tx_out_valid[k];
   endfunction
   // Bounded wait on a flag, a hang ends the run
   task automatic wait_for(input int k);
      int i;
      i = 0;
      while (flag(k) !== 1'b1 && i < 40) begin
         @(negedge clock);
         i++;
      end
      if (flag(k) !== 1'b1) begin
         n_fail++;
         $display("[FAIL] wait %0d expected 1 seen 0", k);
         print_verdict();
      end
   endtask
   task automatic pop(input int ch);
      tx_out_ready[ch] = 1'b1;
      @(negedge clock);
      tx_out_ready[ch] = 1'b0;
      @(negedge clock);
   endtask
   task automatic push(input logic [SPL_DW-1:0] d, input logic [4:0] f);
      @(negedge clock);
      wait_for(3);
      rx_in_data[0] = d;
      {rx_in_sop[0], rx_in_eop[0], rx_in_mod[0], rx_in_err[0]} = f;
      rx_in_valid[0] = 1'b1;
      @(negedge clock);
      rx_in_valid[0] = 1'b0;
      rx_in_data[0] = ~d;
   endtask

   task automatic t_tx_basic();
      link.sel(1'b1);
      link.cyc(1'b0, 1'b0, 32'h1234_5678, 1'b1, 1'b0, 2'h0);
      link.cyc(1'b0, 1'b0, 32'h9abc_def0, 1'b0, 1'b1, 2'h3);
      link.cyc(1'b0, 1'b1, 32'h0f0f_0f0f, 1'b1, 1'b1, 2'h1);
      link.idle();
      wait_for(1);
      chk("first word", tx_out_data[1], 32'h1234_5678);
      chk("first sop", {tx_out_sop[1], tx_out_valid[0]}, 2'h2);
      pop(1);
      wait_for(1);
      chk("last word", tx_out_data[1], 32'h9abc_def0);
      chk("last eop", {tx_out_eop[1], tx_out_mod[1]}, 3'h7);
      pop(1);
      wait_for(1);
      chk("same channel", tx_out_data[1], 32'h0f0f_0f0f);
      chk("same flags", {tx_out_sop[1], tx_out_mod[1]}, 3'h5);
      pop(1);
      repeat (4) @(negedge clock);
      chk("no extra word", tx_out_valid, 2'h0);
      $display("Test tx_basic done");
   endtask
   task automatic t_fill();
      link.sel(1'b0);
      for (int i = 0; i < 14; i++) begin
         link.cyc(1'b0, 1'b0, 32'(i), i == 0, i == 13, 2'h0);
         if (i == 11) begin
            link.idle();
            repeat (4) @(negedge clock);
            chk("dtpa 12 words", {dtpa, stpa}, 3'h7);
         end
      end
      link.idle();
      repeat (4) @(negedge clock);
      chk("dtpa 14 words", {dtpa, stpa}, 3'h4);
      // Three words fill the buffer, the fourth is refused
      for (int i = 0; i < 4; i++) begin
         link.cyc(1'b0, 1'b0, 32'(i + 14), i == 0, i == 3, 2'h0);
      end
      link.idle();
      @(negedge clock);
      chk("overflow", tx_overflow, 1'b1);
      link.sel(1'b1);
      link.idle();
      @(negedge clock);
      chk("stpa reselect", stpa, 1'b1);
      $display("Test fill done");
   endtask
   task automatic t_poll();
      status_mode = 1'b1;
      tadr = 1'b1;
      @(negedge clock);
      chk("ptpa ch1", ptpa, 1'b1);
      chk("stpa in poll", stpa, 1'b1);
      tadr = 1'b0;
      @(negedge clock);
      chk("ptpa ch0", ptpa, 1'b0);
      status_mode = 1'b0;
      tadr = 1'b1;
      @(negedge clock);
      @(negedge clock);
      chk("ptpa byte mode", ptpa, 1'b0);
      tx_out_ready = 2'h1;
      repeat (30) @(negedge clock);
      tx_out_ready = 2'h0;
      chk("dtpa drained", dtpa, 2'h3);
      $display("Test poll done");
   endtask
   task automatic t_par();
      link.bad(32'h5a5a_0003);
      link.idle();
      @(negedge clock);
      chk("parity flag", tx_par_err, 1'b1);
      wait_for(1);
      chk("parity word", tx_out_data[1], 32'h5a5a_0003);
      pop(1);
      chk("parity pulse", tx_par_err, 1'b0);
      $display("Test par done");
   endtask
   task automatic t_rx();
      push(32'hc0de_0001, 5'h10);
      push(32'hc0de_0002, 5'h0d);
      repeat (3) @(negedge clock);
      chk("rx quiet", {rval, rsx}, 2'h0);
      renb_b = 1'b0;
      wait_for(2);
      chk("rx address", rdat, 32'h0);
      @(negedge clock);
      chk("rx word0", {rval, rdat}, {1'b1, 32'hc0de_0001});
      renb_b = 1'b1;
      @(negedge clock);
      chk("rx held", {rsop, rdat}, {1'b1, 32'hc0de_0001});
      renb_b = 1'b0;
      @(negedge clock);
      chk("rx word1", {rval, rdat}, {1'b1, 32'hc0de_0002});
      chk("rx end", {reop, rerr, rmod, rprty},
         {4'he, ~^32'hc0de_0002});
      @(negedge clock);
      chk("rx idle", {rval, rsx}, 2'h0);
      $display("Test rx done");
   endtask

   initial begin
      n_fail = 0;
      tests_run = 0;
      {rst_b, status_mode, tadr, renb_b} = 4'h1;
      {tx_out_ready, rx_in_valid, rx_in_sop, rx_in_eop, rx_in_err} = '0;
      rx_in_data = '{default: '0};
      rx_in_mod = '{default: '0};
      repeat (4) @(negedge clock);
      rst_b = 1'b1;
      @(negedge clock);
      t_tx_basic();
      t_fill();
      t_poll();
      t_par();
      t_rx();
      print_verdict();
   end
endmodule
